// ### include/resv_reg_pkg.sv
// constants for the key registration command block
package resv_reg_pkg;
  // ----------------------------------------
  // command dword 10 fields
  // ----------------------------------------
  localparam int PSC_HI = 31;
  localparam int PSC_LO = 30;
  localparam int SKIP_BIT = 3;
  localparam int ACT_HI = 2;
  localparam int ACT_LO = 0;
  // ----------------------------------------
  // encodings
  // ----------------------------------------
  localparam logic [1:0] PSC_NONE = 2'h0;
  localparam logic [1:0] PSC_RSVD = 2'h1;
  localparam logic [1:0] PSC_CLEAR = 2'h2;
  localparam logic [1:0] PSC_SET = 2'h3;
  localparam logic [2:0] ACT_REGISTER = 3'h0;
  localparam logic [2:0] ACT_UNREGISTER = 3'h1;
  localparam logic [2:0] ACT_REPLACE = 3'h2;
  // ----------------------------------------
  // completion status codes
  // ----------------------------------------
  localparam logic [7:0] ST_SUCCESS = 8'h00;
  localparam logic [7:0] ST_INVALID_FIELD = 8'h02;
  localparam logic [7:0] ST_CONFLICT = 8'h83;
  // ----------------------------------------
  // key structure layout in bits, persistence reset value and page-list descriptor code
  // ----------------------------------------
  localparam int CUR_KEY_LO = 0;
  localparam int NEW_KEY_LO = 64;
  localparam int KEY_W = 64;
  localparam int STRUCT_W = 128;
  localparam logic PERSIST_RESET = 1'b0;
  localparam logic [1:0] DESC_PAGE_LIST = 2'h0;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MASK = 4'h4;
  localparam logic [3:0] REG_STATE = 4'h8;
endpackage

// ### rtl/resv_reg_cmd.sv
// key registration command interpreter with persistence state and completion
`timescale 1ns/1ps
// Summary of operation
// R1 - command parameters come from dword 10; key structure fetched from host memory
// R2 - page-list transfers use only first and second page-list entries
// R3 - scatter-gather transfers use only the first scatter-gather entry
// R4 - dword 10 bits 29:4 and other fields are reserved and ignored
// R5 - 128-bit buffer pointer locates the host buffer for the key structure
// R6 - persistence change 00b leaves state alone; 01b is reserved
// R7 - persistence change 10b clears persistence state to zero
// R8 - persistence change 11b sets persistence state to one
// R9 - with saveable support, change both current and saveable values
// R10 - skip_key_check bit makes key-checking actions skip the comparison
// R11 - registration action field selects the operation
// R12 - 000b register, 001b unregister, 010b replace, others reserved
// R13 - current key is bytes 7:0, used by unregister and replace
// R14 - new key is bytes 15:8, used by register and replace
// R15 - completion entry with status posted to the associated completion queue
// R16 - reserved persistence or action encodings complete with invalid field
module resv_reg_cmd #(
  parameter bit SAVEABLE = 1'b1
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // command from the submission side
  input wire logic CMD_VALID,
  input wire logic [31:0] CMD_DW10,
  input wire logic [127:0] CMD_PTR,
  input wire logic [1:0] CMD_DESC,
  input wire logic [15:0] CMD_ID,
  input wire logic [15:0] CMD_QID,
  output logic CMD_READY,
  // host memory fetch of the key structure
  output logic FETCH_REQ,
  output logic [63:0] FETCH_ADDR1,
  output logic [63:0] FETCH_ADDR2,
  output logic FETCH_USE2,
  input wire logic FETCH_DONE,
  input wire logic [127:0] FETCH_DATA,
  // key store of the namespace
  output logic KEY_OP,
  output logic [2:0] KEY_ACTION,
  output logic KEY_SKIP_CHECK,
  output logic [63:0] KEY_CUR,
  output logic [63:0] KEY_NEW,
  input wire logic KEY_DONE,
  input wire logic KEY_OK,
  // completion queue entry
  output logic CPL_VALID,
  output logic [15:0] CPL_ID,
  output logic [15:0] CPL_QID,
  output logic [7:0] CPL_STATUS,
  input wire logic CPL_READY,
  // persistence state
  output logic PERSIST_CUR,
  output logic PERSIST_SAVE,
  // register port
  input wire logic [3:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  // interrupt
  output logic IRQ
);
  // ----------------------------------------
  // registers: 0 status (w1c), 4 mask, 8 state
  // ----------------------------------------
  localparam logic [3:0] A_STATUS = resv_reg_pkg::REG_STATUS;
  localparam logic [3:0] A_MASK = resv_reg_pkg::REG_MASK;
  localparam logic [3:0] A_STATE = resv_reg_pkg::REG_STATE;

  // ----------------------------------------
  // command state
  // ----------------------------------------
  typedef enum logic [2:0] {IDLE, FETCH, KEYOP, POST} phase_t;

  typedef struct packed {
    phase_t phase;
    logic cmd_ready;
    logic [31:0] dw10;
    logic fetch_req;
    logic [63:0] addr1;
    logic [63:0] addr2;
    logic use2;
    logic key_op;
    logic [2:0] action;
    logic skip;
    logic [63:0] cur_key;
    logic [63:0] new_key;
    logic cpl_valid;
    logic [15:0] cpl_id;
    logic [15:0] cpl_qid;
    logic [7:0] status;
    logic persist_cur;
    logic persist_save;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [31:0] rdata;
    logic irq;
  } state_t;

  state_t s;
  state_t next_s;

  logic [1:0] psc;
  logic bad_field;
  logic [2:0] ev;
  logic [63:0] ptr_first;
  logic [63:0] ptr_second;
  logic [63:0] data_cur;
  logic [63:0] data_new;

  // pointer entries and key structure halves
  assign ptr_first = CMD_PTR[63:0];
  assign ptr_second = CMD_PTR[127:64];
  assign data_cur = FETCH_DATA[resv_reg_pkg::CUR_KEY_LO +: resv_reg_pkg::KEY_W];
  assign data_new = FETCH_DATA[resv_reg_pkg::NEW_KEY_LO +: resv_reg_pkg::KEY_W];

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    ev = 3'h0;
    psc = s.dw10[resv_reg_pkg::PSC_HI:resv_reg_pkg::PSC_LO];
    // R16 reserved encodings
    bad_field = (psc == resv_reg_pkg::PSC_RSVD) ||
                (s.dw10[resv_reg_pkg::ACT_HI:resv_reg_pkg::ACT_LO] > resv_reg_pkg::ACT_REPLACE);
    next_s.rdata = 32'h0000_0000;
    case (s.phase)
      IDLE: begin
        next_s.cmd_ready = 1'b1;
        if (CMD_VALID && s.cmd_ready) begin
          next_s.cmd_ready = 1'b0;
          // R1 latch dword 10
          next_s.dw10 = CMD_DW10;
          next_s.cpl_id = CMD_ID;
          next_s.cpl_qid = CMD_QID;
          // R5 pointer gives host buffer
          next_s.addr1 = ptr_first;
          if (CMD_DESC == resv_reg_pkg::DESC_PAGE_LIST) begin
            // R2 two page-list entries
            next_s.addr2 = ptr_second;
            next_s.use2 = 1'b1;
          end else begin
            // R3 first scatter-gather entry
            next_s.addr2 = 64'h0000_0000_0000_0000;
            next_s.use2 = 1'b0;
          end
          next_s.fetch_req = 1'b1;
          next_s.phase = FETCH;
        end
      end
      FETCH: begin
        next_s.fetch_req = 1'b0;
        if (FETCH_DONE) begin
          // R4 only fields 31:30, 3, 2:0 are decoded
          // R11 select action
          next_s.action = s.dw10[resv_reg_pkg::ACT_HI:resv_reg_pkg::ACT_LO];
          // R10 skip comparison
          next_s.skip = s.dw10[resv_reg_pkg::SKIP_BIT];
          // R13 current key for unregister and replace
          next_s.cur_key = 64'h0000_0000_0000_0000;
          if (!s.dw10[resv_reg_pkg::SKIP_BIT] &&
              s.dw10[resv_reg_pkg::ACT_HI:resv_reg_pkg::ACT_LO] != resv_reg_pkg::ACT_REGISTER)
            next_s.cur_key = data_cur;
          // R14 new key for register and replace
          next_s.new_key = 64'h0000_0000_0000_0000;
          if (s.dw10[resv_reg_pkg::ACT_HI:resv_reg_pkg::ACT_LO] != resv_reg_pkg::ACT_UNREGISTER)
            next_s.new_key = data_new;
          if (bad_field) begin
            next_s.status = resv_reg_pkg::ST_INVALID_FIELD;
            next_s.cpl_valid = 1'b1;
            next_s.phase = POST;
          end else begin
            // R12 valid action reaches key store
            next_s.key_op = 1'b1;
            next_s.phase = KEYOP;
          end
        end
      end
      KEYOP: begin
        next_s.key_op = 1'b0;
        if (KEY_DONE) begin
          if (KEY_OK) begin
            next_s.status = resv_reg_pkg::ST_SUCCESS;
            // R6 R7 R8 persistence change
            if (psc == resv_reg_pkg::PSC_CLEAR || psc == resv_reg_pkg::PSC_SET) begin
              next_s.persist_cur = psc[0];
              // R9 saveable copy follows
              if (SAVEABLE)
                next_s.persist_save = psc[0];
            end
          end else begin
            next_s.status = resv_reg_pkg::ST_CONFLICT;
          end
          next_s.cpl_valid = 1'b1;
          next_s.phase = POST;
        end
      end
      POST: begin
        // R15 post completion
        if (CPL_READY) begin
          next_s.cpl_valid = 1'b0;
          ev[0] = 1'b1;
          ev[1] = (s.status != resv_reg_pkg::ST_SUCCESS);
          ev[2] = (s.status == resv_reg_pkg::ST_SUCCESS) && (psc[1] == 1'b1);
          next_s.phase = IDLE;
        end
      end
      default: next_s.phase = IDLE;
    endcase
    // register access; set wins over clear
    if (REG_WR && REG_ADDR == A_STATUS)
      next_s.irq_status = s.irq_status & ~REG_WDATA[2:0];
    if (REG_WR && REG_ADDR == A_MASK)
      next_s.irq_mask = REG_WDATA[2:0];
    next_s.irq_status = next_s.irq_status | ev;
    if (REG_RD) begin
      case (REG_ADDR)
        A_STATUS: next_s.rdata = {29'h0, s.irq_status};
        A_MASK: next_s.rdata = {29'h0, s.irq_mask};
        A_STATE: next_s.rdata = {27'h0, s.phase, s.persist_save, s.persist_cur};
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
    next_s.irq = |(next_s.irq_status & next_s.irq_mask);
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      s <= '0;
      s.phase <= IDLE;
      s.persist_cur <= resv_reg_pkg::PERSIST_RESET;
      s.persist_save <= resv_reg_pkg::PERSIST_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign CMD_READY = s.cmd_ready;
  assign FETCH_REQ = s.fetch_req;
  assign FETCH_ADDR1 = s.addr1;
  assign FETCH_ADDR2 = s.addr2;
  assign FETCH_USE2 = s.use2;
  assign KEY_OP = s.key_op;
  assign KEY_ACTION = s.action;
  assign KEY_SKIP_CHECK = s.skip;
  assign KEY_CUR = s.cur_key;
  assign KEY_NEW = s.new_key;
  assign CPL_VALID = s.cpl_valid;
  assign CPL_ID = s.cpl_id;
  assign CPL_QID = s.cpl_qid;
  assign CPL_STATUS = s.status;
  assign PERSIST_CUR = s.persist_cur;
  assign PERSIST_SAVE = s.persist_save;
  assign REG_RDATA = s.rdata;
  assign IRQ = s.irq;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // command taken from the submission side
  sequence take_s;
    CMD_VALID && CMD_READY;
  endsequence

  sequence fetch_end_s;
    s.phase == FETCH && FETCH_DONE;
  endsequence

  // fetch ended on a reserved encoding
  sequence refuse_s;
    s.phase == FETCH && FETCH_DONE && bad_field;
  endsequence

  // fetch ended on a valid command
  sequence accept_s;
    s.phase == FETCH && FETCH_DONE && !bad_field;
  endsequence

  // one-cycle request to the key store
  sequence key_pulse_s;
    KEY_OP ##1 !KEY_OP;
  endsequence

  a_take_fetch: assert property (@(posedge CLK) disable iff (RESET) // R1
    take_s |=> FETCH_REQ && s.dw10 == $past(CMD_DW10))
    else $error("dword 10 not taken");
  a_ptr_first: assert property (@(posedge CLK) disable iff (RESET) // R5
    take_s |=> FETCH_ADDR1 == $past(ptr_first))
    else $error("first pointer entry not used");
  a_pl_pair: assert property (@(posedge CLK) disable iff (RESET) // R2
    (CMD_VALID && CMD_READY && CMD_DESC == resv_reg_pkg::DESC_PAGE_LIST)
    |=> FETCH_USE2 && FETCH_ADDR2 == $past(ptr_second))
    else $error("second page-list entry not used");
  a_action_copy: assert property (@(posedge CLK) disable iff (RESET) // R11
    fetch_end_s |=> KEY_ACTION == s.dw10[resv_reg_pkg::ACT_HI:resv_reg_pkg::ACT_LO])
    else $error("action not decoded");
  a_skip_copy: assert property (@(posedge CLK) disable iff (RESET) // R10
    fetch_end_s |=> KEY_SKIP_CHECK == s.dw10[resv_reg_pkg::SKIP_BIT])
    else $error("skip bit not passed");
  a_cur_key: assert property (@(posedge CLK) disable iff (RESET) // R13
    (s.phase == FETCH && FETCH_DONE && !s.dw10[resv_reg_pkg::SKIP_BIT] &&
     s.dw10[resv_reg_pkg::ACT_HI:resv_reg_pkg::ACT_LO] != resv_reg_pkg::ACT_REGISTER)
    |=> KEY_CUR == $past(data_cur))
    else $error("current key not taken");
  a_new_key: assert property (@(posedge CLK) disable iff (RESET) // R14
    (s.phase == FETCH && FETCH_DONE &&
     s.dw10[resv_reg_pkg::ACT_HI:resv_reg_pkg::ACT_LO] != resv_reg_pkg::ACT_UNREGISTER)
    |=> KEY_NEW == $past(data_new))
    else $error("new key not taken");
  a_unreg_new: assert property (@(posedge CLK) disable iff (RESET) // R14
    (s.phase == FETCH && FETCH_DONE &&
     s.dw10[resv_reg_pkg::ACT_HI:resv_reg_pkg::ACT_LO] == resv_reg_pkg::ACT_UNREGISTER)
    |=> KEY_NEW == 64'h0000_0000_0000_0000)
    else $error("new key used by unregister");
  a_keep_save: assert property (@(posedge CLK) disable iff (RESET) // R6
    (psc == resv_reg_pkg::PSC_NONE && s.phase != IDLE) |=> $stable(PERSIST_SAVE))
    else $error("saveable value changed");
  a_cpl_hold: assert property (@(posedge CLK) disable iff (RESET) // R15
    (CPL_VALID && !CPL_READY)
    |=> CPL_VALID && $stable(CPL_STATUS) && $stable(CPL_ID) && $stable(CPL_QID))
    else $error("completion entry dropped");

  a_set_persist: assert property (@(posedge CLK) disable iff (RESET) // R8
    (s.phase == KEYOP && KEY_DONE && KEY_OK && psc == resv_reg_pkg::PSC_SET)
    |=> PERSIST_CUR)
    else $error("persistence not set");
  a_clear_persist: assert property (@(posedge CLK) disable iff (RESET) // R7
    (s.phase == KEYOP && KEY_DONE && KEY_OK && psc == resv_reg_pkg::PSC_CLEAR)
    |=> !PERSIST_CUR)
    else $error("persistence not cleared");
  a_keep_persist: assert property (@(posedge CLK) disable iff (RESET) // R6
    (psc == resv_reg_pkg::PSC_NONE && s.phase != IDLE) |=> $stable(PERSIST_CUR))
    else $error("persistence changed");
  a_save_follows: assert property (@(posedge CLK) disable iff (RESET) // R9
    (SAVEABLE && $changed(PERSIST_CUR)) |-> PERSIST_SAVE == PERSIST_CUR)
    else $error("saveable value lags");
  a_bad_field: assert property (@(posedge CLK) disable iff (RESET) // R16
    refuse_s |=> CPL_VALID && CPL_STATUS == resv_reg_pkg::ST_INVALID_FIELD)
    else $error("reserved field not refused");
  a_good_keyop: assert property (@(posedge CLK) disable iff (RESET) // R12
    accept_s |=> key_pulse_s)
    else $error("key operation not issued");
  a_skip_key: assert property (@(posedge CLK) disable iff (RESET) // R13
    KEY_OP && KEY_SKIP_CHECK |-> KEY_CUR == 64'h0000_0000_0000_0000)
    else $error("current key used while skipped");
  a_sg_single: assert property (@(posedge CLK) disable iff (RESET) // R3
    (CMD_VALID && CMD_READY && CMD_DESC != resv_reg_pkg::DESC_PAGE_LIST)
    |=> FETCH_REQ && !FETCH_USE2)
    else $error("second entry used for scatter-gather");
  a_cpl_post: assert property (@(posedge CLK) disable iff (RESET) // R15
    (s.phase == KEYOP && KEY_DONE) |=> CPL_VALID)
    else $error("completion not posted");
endmodule

// ### bench/host_model.sv
// host memory and namespace key store model facing the command block
`timescale 1ns/1ps
module host_model (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  input wire logic SLOW,
  // key structure fetch
  input wire logic FETCH_REQ,
  input wire logic [63:0] FETCH_ADDR1,
  output logic FETCH_DONE,
  output logic [127:0] FETCH_DATA,
  // key store
  input wire logic KEY_OP,
  input wire logic [2:0] KEY_ACTION,
  input wire logic KEY_SKIP_CHECK,
  input wire logic [63:0] KEY_CUR,
  input wire logic [63:0] KEY_NEW,
  output logic KEY_DONE,
  output logic KEY_OK
);
  logic [63:0] addr;
  logic [63:0] stored;
  logic ok;
  int fc;
  int kc;

  initial begin
    {FETCH_DONE, FETCH_DATA, KEY_DONE, KEY_OK, addr, stored, ok} = '0;
    fc = 0;
    kc = 0;
  end

  always @(posedge CLK) begin
    FETCH_DONE <= 1'b0;
    KEY_DONE <= 1'b0;
    // released lines never hold the last value
    FETCH_DATA <= ~FETCH_DATA;
    KEY_OK <= ~KEY_OK;
    if (RESET) begin
      fc <= 0;
      kc <= 0;
    end else begin
      // key structure sits at the buffer pointer: current key low, new key high
      if (FETCH_REQ) begin
        addr <= FETCH_ADDR1;
        fc <= SLOW ? 6 : 1;
      end else if (fc > 1) begin
        fc <= fc - 1;
      end else if (fc == 1) begin
        fc <= 0;
        FETCH_DONE <= 1'b1;
        FETCH_DATA <= {addr + 64'h0000_0000_0000_0001, addr};
      end
      if (KEY_OP) begin
        ok <= KEY_ACTION == resv_reg_pkg::ACT_REGISTER || KEY_SKIP_CHECK || KEY_CUR == stored;
        if (KEY_ACTION != resv_reg_pkg::ACT_UNREGISTER &&
            (KEY_ACTION == resv_reg_pkg::ACT_REGISTER || KEY_SKIP_CHECK || KEY_CUR == stored))
          stored <= KEY_NEW;
        kc <= SLOW ? 5 : 1;
      end else if (kc > 1) begin
        kc <= kc - 1;
      end else if (kc == 1) begin
        kc <= 0;
        KEY_DONE <= 1'b1;
        KEY_OK <= ok;
      end
    end
  end
endmodule

// ### bench/testbench.sv
// self-checking bench for the key registration command block
`timescale 1ns/1ps
module testbench;
  logic CLK, RESET, CMD_VALID, CMD_READY, FETCH_REQ, FETCH_USE2, FETCH_DONE, KEY_OP, KEY_SKIP;
  logic KEY_DONE, KEY_OK, CPL_VALID, CPL_READY, P_CUR, P_SAVE, REG_WR, REG_RD, IRQ, SLOW;
  logic [1:0] CMD_DESC;
  logic [2:0] KEY_ACTION;
  logic [3:0] REG_ADDR;
  logic [7:0] CPL_STATUS;
  logic [15:0] CMD_ID, CMD_QID, CPL_ID, CPL_QID;
  logic [31:0] CMD_DW10, REG_WDATA, REG_RDATA, dq;
  logic [63:0] FETCH_ADDR1, FETCH_ADDR2, KEY_CUR, KEY_NEW;
  logic [127:0] CMD_PTR, FETCH_DATA, pq;
  int miscompares, compares;

  resv_reg_cmd dut (.CLK(CLK), .RESET(RESET), .CMD_VALID(CMD_VALID), .CMD_DW10(CMD_DW10),
    .CMD_PTR(CMD_PTR), .CMD_DESC(CMD_DESC), .CMD_ID(CMD_ID), .CMD_QID(CMD_QID),
    .CMD_READY(CMD_READY), .FETCH_REQ(FETCH_REQ), .FETCH_ADDR1(FETCH_ADDR1),
    .FETCH_ADDR2(FETCH_ADDR2), .FETCH_USE2(FETCH_USE2), .FETCH_DONE(FETCH_DONE),
    .FETCH_DATA(FETCH_DATA), .KEY_OP(KEY_OP), .KEY_ACTION(KEY_ACTION), .KEY_SKIP_CHECK(KEY_SKIP),
    .KEY_CUR(KEY_CUR), .KEY_NEW(KEY_NEW), .KEY_DONE(KEY_DONE), .KEY_OK(KEY_OK),
    .CPL_VALID(CPL_VALID), .CPL_ID(CPL_ID), .CPL_QID(CPL_QID), .CPL_STATUS(CPL_STATUS),
    .CPL_READY(CPL_READY), .PERSIST_CUR(P_CUR), .PERSIST_SAVE(P_SAVE), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IRQ(IRQ));
  host_model host (.CLK(CLK), .RESET(RESET), .SLOW(SLOW), .FETCH_REQ(FETCH_REQ),
    .FETCH_ADDR1(FETCH_ADDR1), .FETCH_DONE(FETCH_DONE), .FETCH_DATA(FETCH_DATA), .KEY_OP(KEY_OP),
    .KEY_ACTION(KEY_ACTION), .KEY_SKIP_CHECK(KEY_SKIP), .KEY_CUR(KEY_CUR), .KEY_NEW(KEY_NEW),
    .KEY_DONE(KEY_DONE), .KEY_OK(KEY_OK));

  always #5 CLK = ~CLK;

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %0h want %0h", $time, what, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    @(negedge CLK);
    chk(REG_RDATA & m, exp, "reg read");
  endtask

  // offer one command, follow it to its completion, then check status and persistence
  task automatic run_cmd(input logic [31:0] dw, input logic [63:0] a1, input logic [1:0] ds,
                         input logic [7:0] st, input logic p);
    int n;
    dq = dw;
    pq = {a1 + 64'h0000_0000_0001_0000, a1};
    @(posedge CLK);
    {CMD_DW10, CMD_PTR, CMD_DESC, CMD_VALID} <= {dw, pq, ds, 1'b1};
    CMD_ID <= CMD_ID + 16'h0001;
    @(negedge CLK);
    for (n = 0; n < 50 && CMD_READY !== 1'b1; n++) @(negedge CLK);
    @(posedge CLK);
    {CMD_DW10, CMD_PTR, CMD_VALID} <= {~dw, ~pq, 1'b0};
    for (n = 0; n < 100 && CPL_VALID !== 1'b1; n++) @(negedge CLK);
    chk(CPL_VALID, 1'b1, "completion");
    chk(CPL_STATUS, st, "status");
    chk({CPL_ID, CPL_QID}, {CMD_ID, CMD_QID}, "cpl id");
    chk({P_CUR, P_SAVE}, {p, p}, "persist");
    @(posedge CLK);
    CPL_READY <= 1'b1;
    @(posedge CLK);
    CPL_READY <= 1'b0;
    $display("command %0h done", dw);
  endtask

  always @(negedge CLK) begin
    if (FETCH_REQ === 1'b1) begin
      chk(FETCH_ADDR1, pq[63:0], "addr1");
      chk(FETCH_USE2, CMD_DESC == resv_reg_pkg::DESC_PAGE_LIST, "use2");
      if (CMD_DESC == resv_reg_pkg::DESC_PAGE_LIST) chk(FETCH_ADDR2, pq[127:64], "addr2");
    end
    if (KEY_OP === 1'b1) begin
      chk({KEY_SKIP, KEY_ACTION}, dq[3:0], "action");
      chk(KEY_CUR, (dq[3] || dq[2:0] == 3'h0) ? 64'h0 : pq[63:0], "cur key");
      chk(KEY_NEW, dq[2:0] == 3'h1 ? 64'h0 : pq[63:0] + 64'h1, "new key");
    end
  end

  initial begin
    repeat (20000) @(posedge CLK);
    miscompares++;
    wrap_up();
  end

  initial begin
    CLK = 1'b0;
    RESET = 1'b1;
    {CMD_VALID, CMD_DW10, CMD_PTR, CMD_DESC, CMD_ID, CPL_READY, REG_WDATA, REG_WR, REG_RD} = '0;
    {REG_ADDR, SLOW, dq, pq, miscompares, compares} = '0;
    CMD_QID = 16'h0003;
    repeat (3) @(posedge CLK);
    RESET <= 1'b0;
    @(negedge CLK);
    chk({CMD_READY, P_CUR, P_SAVE, IRQ, CPL_VALID}, 5'h00, "reset");
    run_cmd(32'hC000_0000, 64'h1000, 2'h0, resv_reg_pkg::ST_SUCCESS, 1'b1);
    SLOW <= 1'b1;
    run_cmd(32'h8000_0002, 64'h5000, 2'h0, resv_reg_pkg::ST_CONFLICT, 1'b1);
    run_cmd(32'h0000_000A, 64'h7000, 2'h1, resv_reg_pkg::ST_SUCCESS, 1'b1);
    run_cmd(32'h8000_0001, 64'h7001, 2'h0, resv_reg_pkg::ST_SUCCESS, 1'b0);
    run_cmd(32'h4000_0000, 64'h9000, 2'h0, resv_reg_pkg::ST_INVALID_FIELD, 1'b0);
    for (int a = 3; a < 8; a++)
      run_cmd({29'h0, a[2:0]}, 64'hA000, 2'h1, resv_reg_pkg::ST_INVALID_FIELD, 1'b0);
    @(negedge CLK);
    chk(IRQ, 1'b0, "masked irq");
    reg_wr(4'h4, 32'h0000_0007);
    reg_rd(4'h0, 32'hFFFF_FFFF, 32'h0000_0007);
    chk(IRQ, 1'b1, "irq");
    reg_rd(4'h8, 32'h0000_0003, 32'h0000_0000);
    reg_wr(4'h0, 32'h0000_0007);
    reg_rd(4'h0, 32'hFFFF_FFFF, 32'h0000_0000);
    chk(IRQ, 1'b0, "irq clear");
    reg_rd(4'hC, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("register test done");
    wrap_up();
  end
endmodule
